// >>> lbm_regs.svh
// Constants of the local bus master: bit positions, reset values, counts
`ifndef LBM_REGS_SVH
`define LBM_REGS_SVH

// Multiplexed bus layout during the address cycle
`define LBM_BUS_W       32
`define LBM_SIZE_LSB    0
`define LBM_SIZE_MSB    1
`define LBM_ADDR_LSB    2
`define LBM_ADDR_MSB    31

// Burst length in words and size code width
`define LBM_MAX_WORDS   4
`define LBM_SIZE_W      2

// Internal clock is the double-rate clock divided by this
`define LBM_CLK_DIV     2

// Idle value of byte lane strobes, reset value of bus lines
`define LBM_BE_IDLE     4'hf
`define LBM_LAD_RST     32'h0000_0000

`endif

// >>> lbm_pkg.sv
// Types shared by the local bus master and its read buffer
package lbm_pkg;

    // Bus phase of the master
    typedef enum logic [2:0] {
        LBM_IDLE  = 3'b000,
        LBM_ADDR  = 3'b001,
        LBM_DATA  = 3'b010,
        LBM_HOLD  = 3'b011,
        LBM_LOCKW = 3'b100
    } lbm_state_t;

    // One transaction request from the core side
    typedef struct packed {
        logic [29:0]      word_addr;
        logic [1:0]       size;
        logic             write;
        logic             read_modify_write;
        logic             inta;
        logic [3:0][3:0]  be_n;
        logic [3:0][31:0] wdata;
    } lbm_req_t;

endpackage : lbm_pkg

// >>> lbm_pipe_buf.sv
// Small valid/ready buffer that carries read words to the core
`timescale 1ns/10ps
`default_nettype none

module lbm_pipe_buf
    import lbm_pkg::*;
#(
    parameter int WIDTH = 32,
    parameter int DEPTH = 2
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    // Pointers wrap by power of two only
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("lbm_pipe_buf: DEPTH must be a power of two, at least 2");
    end

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0]    wp_q;
    logic [PW-1:0]    rp_q;
    logic [PW:0]      cnt_q;
    wire              push = in_valid & in_ready;
    wire              pop  = out_valid & out_ready;

    // Honest full and empty from the fill count
    assign in_ready  = (cnt_q < (PW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem_q[rp_q];

    // Pointers and fill count
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end else begin
            wp_q  <= wp_q + PW'(push);
            rp_q  <= rp_q + PW'(pop);
            cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
        end
    end

    // Storage written at the write pointer
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wp_q] <= in_data;
        end
    end

endmodule // lbm_pipe_buf
`default_nettype wire

// >>> lbm_master.sv
// Processor-side master of the 32-bit multiplexed local bus
// Behaviour
// - Internal clock is the double-rate clock divided by two.
// - Address cycle drives word address on lines 2-31, size code on 0-1.
// - Data cycles carry read or write data on all 32 lines.
// - Size code: 00 one, 01 two, 10 three, 11 four words.
// - Lines float whenever no address or write data is driven.
// - Address latch strobe low in address cycle, removed before data cycle.
// - Address latch strobe floats during hold cycle.
// - Address-state strobe asserted each address cycle, deasserted next data cycle.
// - In bursts, address-state strobe reasserted after a cycle with ready.
// - Write-not-read given in address cycle, held through data cycles.
// - Direction low for reads and acknowledges, high for writes.
// - Direction never changes while data enable strobe is asserted.
// - No ready extends data cycle by wait cycle without address-state strobe.
// - Lock line is shared open-drain, any agent may assert it.
// - Read-modify-write waits while another agent holds lock.
// - Lock asserted in read address cycle, released in write address cycle.
// - Lock asserted throughout interrupt-acknowledge transactions.
// - Bus request floats lines, asserts hold grant until request drops.
// - Byte lane selects lead data by one cycle.
`timescale 1ns/10ps
`default_nettype none
`include "lbm_regs.svh"

module lbm_master
    import lbm_pkg::*;
(
    input  wire logic        MCLK,
    input  wire logic        RESETN,
    input  wire logic        REQ_VALID,
    output logic             REQ_READY,
    input  wire lbm_req_t    REQ,
    output logic             RD_VALID,
    input  wire logic        RD_READY,
    output logic [31:0]      RD_DATA,
    input  wire logic [31:0] ADDR_DATA_LINES_I,
    output logic [31:0]      ADDR_DATA_LINES_O,
    output logic             ADDR_DATA_LINES_OE,
    output logic             ALE_N_O,
    output logic             ALE_N_OE,
    output logic             ADDR_STATE_STROBE_N_O,
    output logic             ADDR_STATE_STROBE_N_OE,
    output logic             WRITE_NOT_READ_O,
    output logic             WRITE_NOT_READ_OE,
    output logic             TRANSFER_DIRECTION_O,
    output logic             TRANSFER_DIRECTION_OE,
    output logic             DATA_ENABLE_STROBE_N_O,
    output logic             DATA_ENABLE_STROBE_N_OE,
    output logic [3:0]       BYTE_LANE_SELECTS_N_O,
    output logic             BYTE_LANE_SELECTS_N_OE,
    input  wire logic        READY_N,
    input  wire logic        LOCK_N_I,
    output logic             LOCK_N_O,
    output logic             LOCK_N_OE,
    input  wire logic        HOLD,
    output logic             HOLD_GRANT
);

    ////////////////////////////////////////////////////////////////////////
    // State and registers

    lbm_state_t  st_q;
    lbm_state_t  st_d;
    logic        ph_q;
    lbm_req_t    req_q;
    lbm_req_t    req_d;
    logic [1:0]  idx_q;
    logic [1:0]  idx_d;
    logic        rdy_prev_q;
    logic        rmw_wr_q;
    logic        rmw_wr_d;
    logic        lock_q;
    logic        lock_d;
    logic [31:0] lad_q;
    logic        lad_oe_q;
    logic [31:0] rd_hold_q [`LBM_MAX_WORDS];
    logic [2:0]  rd_left_q;
    logic [1:0]  rd_drn_q;

    ////////////////////////////////////////////////////////////////////////
    // Decodes

    // Next word slot of a burst, held at the last, used only by byte lane selection
    function automatic logic [1:0] next_slot(input logic [1:0] i, input logic [1:0] sz);
        next_slot = (i == sz) ? i : 2'(i + 2'h1);
    endfunction

    // Second half of each internal clock ends a bus cycle
    wire cyc_end   = ph_q;
    wire rdy       = ~READY_N;
    wire last      = (idx_q == req_q.size);
    wire eff_wr    = req_q.write & ~req_q.inta;
    wire cur_wr    = eff_wr | rmw_wr_q;
    wire lock_other = ~LOCK_N_I & ~lock_q;
    wire buf_ready;
    wire drain     = buf_ready & (rd_left_q != 3'h0);
    wire capture   = (st_q == LBM_DATA) & cyc_end & rdy & ~cur_wr;
    wire accept    = (st_q == LBM_IDLE) & cyc_end & ~HOLD & REQ_VALID
                     & (rd_left_q == 3'h0);
    wire start_rmw = accept & REQ.read_modify_write & ~REQ.inta;
    wire burst_end = (st_q == LBM_DATA) & cyc_end & rdy & last;
    wire to_addr   = (st_d == LBM_ADDR) & (st_q != LBM_ADDR);
    wire nxt_wr    = (req_d.write & ~req_d.inta) | rmw_wr_d;

    assign REQ_READY = (st_q == LBM_IDLE) & cyc_end & ~HOLD & (rd_left_q == 3'h0);

    ////////////////////////////////////////////////////////////////////////
    // Next bus phase

    // Phase sequencing across idle, address, data, wait and hold cycles
    always_comb begin
        st_d = st_q;
        case (st_q)
            LBM_IDLE: begin
                if (cyc_end && HOLD) begin
                    st_d = LBM_HOLD;
                end else if (accept && start_rmw && ~LOCK_N_I) begin
                    st_d = LBM_LOCKW;
                end else if (accept) begin
                    st_d = LBM_ADDR;
                end
            end
            LBM_LOCKW: begin
                if (cyc_end && !lock_other) begin
                    st_d = LBM_ADDR;
                end
            end
            LBM_ADDR: begin
                if (cyc_end) begin
                    st_d = LBM_DATA;
                end
            end
            LBM_DATA: begin
                // Without ready the data cycle repeats as a wait cycle
                if (burst_end) begin
                    st_d = (req_q.read_modify_write && !rmw_wr_q) ? LBM_ADDR : LBM_IDLE;
                end
            end
            LBM_HOLD: begin
                if (cyc_end && !HOLD) begin
                    st_d = LBM_IDLE;
                end
            end
            default: begin
                st_d = LBM_IDLE;
            end
        endcase
    end

    // Request latch, burst index, write half of read-modify-write, lock
    always_comb begin
        req_d    = accept ? REQ : req_q;
        rmw_wr_d = rmw_wr_q;
        idx_d    = idx_q;
        lock_d   = lock_q;
        if (accept) begin
            rmw_wr_d = 1'b0;
        end else if (burst_end && req_q.read_modify_write && !rmw_wr_q) begin
            rmw_wr_d = 1'b1;
        end else if (burst_end) begin
            rmw_wr_d = 1'b0;
        end
        if (to_addr) begin
            idx_d  = 2'h0;
            lock_d = ((req_d.read_modify_write & ~rmw_wr_d) | req_d.inta);
        end else if (st_q == LBM_DATA && cyc_end && rdy && !last) begin
            idx_d = 2'(idx_q + 2'h1);
        end else if (burst_end) begin
            lock_d = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequential core

    // Divider, phase, latched request and lock
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            ph_q     <= 1'b0;
            st_q     <= LBM_IDLE;
            req_q    <= '0;
            idx_q    <= 2'h0;
            rmw_wr_q <= 1'b0;
            lock_q   <= 1'b0;
        end else begin
            ph_q     <= ~ph_q;
            st_q     <= st_d;
            req_q    <= req_d;
            idx_q    <= idx_d;
            rmw_wr_q <= rmw_wr_d;
            lock_q   <= lock_d;
        end
    end

    // Ready seen in the previous data cycle of a burst
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            rdy_prev_q <= 1'b0;
        end else if (cyc_end) begin
            rdy_prev_q <= (st_q == LBM_DATA) & rdy & ~last;
        end
    end

    // Bus drive value and enable for the coming half cycle
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            lad_q    <= `LBM_LAD_RST;
            lad_oe_q <= 1'b0;
        end else begin
            lad_q    <= (st_d == LBM_ADDR)
                        ? {req_d.word_addr, req_d.size}
                        : req_d.wdata[idx_d];
            lad_oe_q <= (st_d == LBM_ADDR) | ((st_d == LBM_DATA) & nxt_wr);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read words: burst capture and drain into the buffer

    // Holding slots cover a full burst, so a stalled core loses nothing
    always_ff @(posedge MCLK) begin
        if (capture) begin
            rd_hold_q[idx_q] <= ADDR_DATA_LINES_I;
        end
    end

    // Count of captured words not yet in the buffer
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            rd_left_q <= 3'h0;
            rd_drn_q  <= 2'h0;
        end else begin
            rd_left_q <= rd_left_q + 3'(capture) - 3'(drain);
            rd_drn_q  <= accept ? 2'h0 : 2'(rd_drn_q + 2'(drain));
        end
    end

    lbm_pipe_buf #(
        .WIDTH (32),
        .DEPTH (2)
    ) u_rd_buf (
        .clk       (MCLK),
        .rst_n     (RESETN),
        .in_valid  (rd_left_q != 3'h0),
        .in_ready  (buf_ready),
        .in_data   (rd_hold_q[rd_drn_q]),
        .out_valid (RD_VALID),
        .out_ready (RD_READY),
        .out_data  (RD_DATA)
    );

    ////////////////////////////////////////////////////////////////////////
    // Pin drive

    wire own  = (st_q != LBM_HOLD);
    wire data = (st_q == LBM_DATA);
    wire addr_state_strobe_n  = (st_q == LBM_ADDR) | (data & rdy_prev_q);

    // Multiplexed lines
    assign ADDR_DATA_LINES_O  = lad_q;
    assign ADDR_DATA_LINES_OE = lad_oe_q & own;

    // Address latch strobe low only in first half of address cycle
    assign ALE_N_O  = ~((st_q == LBM_ADDR) & ~ph_q);
    assign ALE_N_OE = own;

    // Open-drain address-state strobe pulls low when active
    assign ADDR_STATE_STROBE_N_O  = 1'b0;
    assign ADDR_STATE_STROBE_N_OE = addr_state_strobe_n;

    // Direction and write-not-read change only when a request is latched or a read-modify-write half ends
    assign WRITE_NOT_READ_O      = cur_wr;
    assign WRITE_NOT_READ_OE     = own;
    assign TRANSFER_DIRECTION_O  = cur_wr;
    assign TRANSFER_DIRECTION_OE = own;

    // Data enable strobe active through data and wait cycles
    assign DATA_ENABLE_STROBE_N_O  = ~data;
    assign DATA_ENABLE_STROBE_N_OE = own;

    // Byte lane selects lead their data word by one cycle
    assign BYTE_LANE_SELECTS_N_O  = (st_q == LBM_ADDR) ? req_q.be_n[0]
                                  : data ? req_q.be_n[next_slot(idx_q, req_q.size)]
                                  : `LBM_BE_IDLE;
    assign BYTE_LANE_SELECTS_N_OE = own;

    // Shared lock line pulled low while this master holds it
    assign LOCK_N_O  = 1'b0;
    assign LOCK_N_OE = lock_q & own;

    assign HOLD_GRANT = (st_q == LBM_HOLD);

endmodule // lbm_master
`default_nettype wire

// >>> lbm_master_properties.sv
// Pin-level checks of the local bus master
`timescale 1ns/10ps
`default_nettype none

module lbm_master_properties (
    input wire logic        MCLK,
    input wire logic        RESETN,
    input wire logic        ADDR_DATA_LINES_OE,
    input wire logic        ALE_N_O,
    input wire logic        ALE_N_OE,
    input wire logic        ADDR_STATE_STROBE_N_OE,
    input wire logic        WRITE_NOT_READ_O,
    input wire logic        TRANSFER_DIRECTION_O,
    input wire logic        DATA_ENABLE_STROBE_N_O,
    input wire logic        READY_N,
    input wire logic        LOCK_N_OE,
    input wire logic        HOLD,
    input wire logic        HOLD_GRANT
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RESETN);

    // Decoded bus phases
    wire ale = !ALE_N_O && ALE_N_OE;
    wire data_enable_strobe_n = !DATA_ENABLE_STROBE_N_O;

    ////////////////////////////////////////////////////////////////////////////
    ads_addr_a: assert property (ale |-> ADDR_STATE_STROBE_N_OE ##1 ADDR_STATE_STROBE_N_OE)
        else $error("status strobe missing in address cycle");
    ale_short_a: assert property (ale |=> !ale && !data_enable_strobe_n)
        else $error("latch strobe overlaps data");
    addr_drive_a: assert property (ale |-> ADDR_DATA_LINES_OE)
        else $error("address not driven");
    hold_float_a: assert property (HOLD_GRANT |-> !ALE_N_OE && !ADDR_DATA_LINES_OE
        && !ADDR_STATE_STROBE_N_OE && !LOCK_N_OE)
        else $error("lines driven during hold");
    hold_release_a: assert property ($fell(HOLD) |-> ##[1:4] !HOLD_GRANT)
        else $error("grant not released");
    dir_stable_a: assert property (data_enable_strobe_n && $past(data_enable_strobe_n) |-> $stable(TRANSFER_DIRECTION_O))
        else $error("direction moved under data enable");
    dir_match_a: assert property (data_enable_strobe_n |-> TRANSFER_DIRECTION_O == WRITE_NOT_READ_O)
        else $error("direction and write flag differ");
    read_float_a: assert property (data_enable_strobe_n && !TRANSFER_DIRECTION_O |-> !ADDR_DATA_LINES_OE)
        else $error("lines driven during read data");
    write_drive_a: assert property (data_enable_strobe_n && TRANSFER_DIRECTION_O |-> ADDR_DATA_LINES_OE)
        else $error("write data not driven");
    burst_ads_a: assert property (ADDR_STATE_STROBE_N_OE && data_enable_strobe_n
        |-> !$past(READY_N) || !$past(READY_N, 2))
        else $error("status strobe after wait");

    // Main scenarios reached
    cover property (ale && LOCK_N_OE);
    cover property (HOLD_GRANT);
    cover property (ADDR_STATE_STROBE_N_OE && data_enable_strobe_n);
endmodule // lbm_master_properties

`default_nettype wire

// >>> lbm_slave_model.sv
// Memory slave on the far side of the local bus
`timescale 1ns/10ps
`default_nettype none

module lbm_slave_model (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        slow,
    input  wire logic [31:0] dev_o,
    input  wire logic        dev_oe,
    input  wire logic        ale_n,
    input  wire logic        den_n,
    input  wire logic        dir,
    output logic             ready_n,
    output logic      [31:0] bus
);
    logic [31:0] mem [256];
    logic [7:0]  a_q;
    logic        ph_q;
    logic        wt_q;
    logic [31:0] last_q;

    // Seeded contents, same pattern as the bench
    initial for (int i = 0; i < 256; i++) mem[i] = ~{22'h0, i[7:0], 2'b01};

    // Wire level: master, read data, else a toggling pattern
    assign bus = dev_oe ? dev_o : (!den_n && !dir) ? mem[a_q] : ~last_q;

    // Cycle tracking, capture and ready pacing
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ph_q    <= 1'b0;
            wt_q    <= 1'b0;
            ready_n <= 1'b1;
            last_q  <= 32'h0;
        end else begin
            last_q <= bus;
            ph_q   <= !ale_n ? 1'b1 : ~ph_q;
            if (!ale_n) begin
                a_q <= bus[9:2];
            end else if (ph_q && !den_n && !ready_n) begin
                if (dir) mem[a_q] <= bus;
                a_q <= a_q + 8'h01;
            end
            if (ph_q) begin
                wt_q    <= slow && !wt_q;
                ready_n <= slow && !wt_q;
            end
        end
    end
endmodule // lbm_slave_model

`default_nettype wire

// >>> test_lbm_master.sv
// Self-checking bench of the local bus master
`timescale 1ns/10ps
`default_nettype none

module test_lbm_master
    import lbm_pkg::*;
;
    logic        mclk = 0, resetn = 0, req_valid = 0, rd_ready = 0;
    logic        hold = 0, slow = 0, stall = 0, other_lock = 0;
    lbm_req_t    req = '0;
    logic        req_ready, rd_valid, ale_o, ale_oe, wnr, dir, den_n, lock_oe, grant, lad_oe;
    logic [31:0] rd_data, lad_o, lad_i, rng = 32'd75469;
    logic        ready_n;
    logic [3:0]  be_o;
    wire         lock_n = !(lock_oe || other_lock);
    int          n_errors = 0, num_checks = 0, cyc = 0, n_ale = 0, m;
    logic [31:0] shadow [256];
    logic [37:0] bus_q [$];
    logic [31:0] rd_q [$];

    lbm_master i_dut (.MCLK(mclk), .RESETN(resetn), .REQ_VALID(req_valid),
        .REQ_READY(req_ready), .REQ(req), .RD_VALID(rd_valid), .RD_READY(rd_ready),
        .RD_DATA(rd_data), .ADDR_DATA_LINES_I(lad_i), .ADDR_DATA_LINES_O(lad_o),
        .ADDR_DATA_LINES_OE(lad_oe), .ALE_N_O(ale_o), .ALE_N_OE(ale_oe),
        .ADDR_STATE_STROBE_N_O(), .ADDR_STATE_STROBE_N_OE(), .WRITE_NOT_READ_O(wnr),
        .WRITE_NOT_READ_OE(), .TRANSFER_DIRECTION_O(dir), .TRANSFER_DIRECTION_OE(),
        .DATA_ENABLE_STROBE_N_O(den_n), .DATA_ENABLE_STROBE_N_OE(),
        .BYTE_LANE_SELECTS_N_O(be_o), .BYTE_LANE_SELECTS_N_OE(), .READY_N(ready_n),
        .LOCK_N_I(lock_n), .LOCK_N_O(), .LOCK_N_OE(lock_oe), .HOLD(hold),
        .HOLD_GRANT(grant));

    lbm_slave_model i_slave (.clk(mclk), .rst_n(resetn), .slow(slow), .dev_o(lad_o),
        .dev_oe(lad_oe), .ale_n(!ale_oe || ale_o), .den_n(den_n), .dir(dir),
        .ready_n(ready_n), .bus(lad_i));

    function automatic logic [31:0] xs(logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    task automatic chk_word(string nm, logic [31:0] exp, logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic chk_bus(logic [37:0] exp, logic [37:0] got);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected address cycle: expected %h seen %h", exp, got);
        end
    endtask

    task automatic wrap_up;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // Issue one request and note what it should produce
    task automatic do_req(logic [29:0] a, logic [1:0] sz, logic w, logic rm, logic ia);
        logic [31:0] wd [4];
        logic [15:0] be;
        int k;
        for (k = 0; k < 4; k++) wd[k] = rng ^ k;
        be = rng[23:8];
        req <= '{word_addr: a, size: sz, write: w, read_modify_write: rm, inta: ia, be_n: be,
            wdata: {wd[3], wd[2], wd[1], wd[0]}};
        req_valid <= 1'b1;
        k = 0;
        do begin
            @(posedge mclk);
            k++;
        end while (req_ready !== 1'b1 && k < 300);
        req_valid <= 1'b0;
        chk_word("request taken", 1, req_ready);
        if (rm) begin
            bus_q.push_back({be[3:0], 2'b10, a, 2'b00});
            bus_q.push_back({be[3:0], 2'b01, a, 2'b00});
            rd_q.push_back(shadow[a[7:0]]);
            shadow[a[7:0]] = wd[0];
        end else begin
            bus_q.push_back({be[3:0], ia, w, a, sz});
            for (k = 0; k <= sz; k++)
                if (w) shadow[8'(a[7:0] + k)] = wd[k];
                else rd_q.push_back(shadow[8'(a[7:0] + k)]);
        end
        // Let one edge pass so the next call does not re-raise valid at once
        @(posedge mclk);
    endtask

    // Clock, timeout, sink pacing and random source
    always #2 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        rng <= xs(rng);
        rd_ready <= !stall && rng[0];
        if (cyc == 60000) begin
            n_errors++;
            wrap_up;
        end
    end

    // Watch address cycles and read words
    always @(posedge mclk) begin
        if (!ale_o && ale_oe) begin
            n_ale++;
            chk_bus(bus_q.size() ? bus_q.pop_front() : 'x, {be_o, lock_oe, dir, lad_o});
        end
        if (rd_valid && rd_ready)
            chk_word("read word", rd_q.size() ? rd_q.pop_front() : 'x, rd_data);
    end

    // Main sequence
    initial begin
        for (int i = 0; i < 256; i++) shadow[i] = ~{22'h0, i[7:0], 2'b01};
        repeat (12) @(posedge mclk);
        resetn <= 1'b1;
        repeat (2) @(posedge mclk);
        for (int s = 0; s < 4; s++) begin
            slow <= s[0];
            do_req(30'h3fff_fffe, s[1:0], 1'b1, 1'b0, 1'b0);
            do_req(30'h3fff_fffe, s[1:0], 1'b0, 1'b0, 1'b0);
        end
        do_req(30'h0000_0123, 2'b00, 1'b0, 1'b0, 1'b1);
        do_req(30'h0000_0040, 2'b00, 1'b0, 1'b1, 1'b0);
        // Foreign agent starts its own locked cycle only once ours is over
        repeat (20) @(posedge mclk);
        other_lock <= 1'b1;
        m = n_ale;
        do_req(30'h0000_0041, 2'b00, 1'b0, 1'b1, 1'b0);
        repeat (30) @(posedge mclk);
        chk_word("cycles under foreign lock", m, n_ale);
        other_lock <= 1'b0;
        stall <= 1'b1;
        do_req(30'h0000_0080, 2'b11, 1'b0, 1'b0, 1'b0);
        repeat (40) @(posedge mclk);
        stall <= 1'b0;
        hold <= 1'b1;
        for (m = 0; m < 40 && grant !== 1'b1; m++) @(posedge mclk);
        chk_word("hold grant", 1, grant);
        hold <= 1'b0;
        repeat (8) @(posedge mclk);
        chk_word("hold grant", 0, grant);
        repeat (16) begin
            slow <= rng[6];
            do_req(rng[29:0], rng[31:30], rng[5], 1'b0, 1'b0);
        end
        for (m = 0; m < 400 && (rd_q.size() + bus_q.size()) > 0; m++) @(posedge mclk);
        chk_word("pending notes", 0, rd_q.size() + bus_q.size());
        wrap_up;
    end
endmodule // test_lbm_master

bind lbm_master lbm_master_properties i_props (.MCLK(MCLK), .RESETN(RESETN),
    .ADDR_DATA_LINES_OE(ADDR_DATA_LINES_OE), .ALE_N_O(ALE_N_O), .ALE_N_OE(ALE_N_OE),
    .ADDR_STATE_STROBE_N_OE(ADDR_STATE_STROBE_N_OE), .WRITE_NOT_READ_O(WRITE_NOT_READ_O),
    .TRANSFER_DIRECTION_O(TRANSFER_DIRECTION_O), .READY_N(READY_N),
    .DATA_ENABLE_STROBE_N_O(DATA_ENABLE_STROBE_N_O), .LOCK_N_OE(LOCK_N_OE),
    .HOLD(HOLD), .HOLD_GRANT(HOLD_GRANT));

`default_nettype wire
